//--- logic/epp_defs.svh
`ifndef EPP_DEFS_SVH
`define EPP_DEFS_SVH
// ********
// clock and timing
// ********
`define EPP_CLK_MHZ 40
`define EPP_FUSE_WAIT_US 4500
`define EPP_FLASH_WAIT_US 4500
`define EPP_EE_WAIT_US 9000
`define EPP_ERASE_WAIT_US 9000
// ********
// parallel commands
// ********
`define EPP_CMD_ERASE 8'h80
`define EPP_CMD_FUSE 8'h40
`define EPP_CMD_LOCK 8'h20
`define EPP_CMD_RD_SIG 8'h08
`define EPP_CMD_RD_FL 8'h04
`define EPP_CMD_RD_EE 8'h03
// ********
// serial instruction bytes
// ********
`define EPP_SI_PEN 8'hAC
`define EPP_SI_SYNC 8'h53
`define EPP_SI_ERASE 3'h4
`define EPP_SI_WLOCK 3'h7
`define EPP_SI_WFUSE 8'hA0
`define EPP_SI_RDPL 8'h20
`define EPP_SI_RDPH 8'h28
`define EPP_SI_LDPL 8'h40
`define EPP_SI_LDPH 8'h48
`define EPP_SI_WRPG 8'h4C
`define EPP_SI_RDEE 8'hA0
`define EPP_SI_WREE 8'hC0
`define EPP_SI_RDLK 8'h58
`define EPP_SI_RDSIG 8'h30
// ********
// fields and reset values
// ********
`define EPP_BOOT_LOCK_MASK 8'h3C
`define EPP_LOCK_TOP 8'hC0
`define EPP_ERASED 8'hFF
`define EPP_FUSE_LO_RST 8'hFF
`define EPP_FUSE_HI_RST 8'hFF
`define EPP_FUSE_EXT_RST 8'hFF
`define EPP_LOCK_RST 8'hFF
// ********
// register offsets and response codes
// ********
`define EPP_REG_STATUS 4'h0
`define EPP_REG_FUSE 4'h4
`define EPP_REG_LOCK 4'h8
`define EPP_REG_CTRL 4'hC
`define EPP_RESP_OKAY 2'h0
`define EPP_RESP_SLVERR 2'h2
`endif

//--- logic/epp_pkg.sv
package epp_pkg;
  // background sweep of the arrays
  typedef enum logic [1:0] {
    SW_IDLE = 2'b00,
    SW_ERASE = 2'b01,
    SW_COPY = 2'b10
  } epp_sweep_t;
  // source of the fourth serial answer byte
  typedef enum logic [2:0] {
    RS_ECHO = 3'b000,
    RS_FLASH = 3'b001,
    RS_EE = 3'b010,
    RS_LOCK = 3'b011,
    RS_SIG = 3'b100
  } epp_rsel_t;
endpackage : epp_pkg

//--- logic/epp_mem_if.sv
`timescale 1ns/100ps
interface epp_mem_if #(parameter int AW = 8);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport user (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : epp_mem_if

//--- logic/epp_mem.sv
`timescale 1ns/100ps
module epp_mem #(
  parameter int AW = 8 // address bits
) (
  input wire logic aclk, // system clock
  epp_mem_if.mem bus // array access
);
  logic [7:0] cells [0:(1<<AW)-1];
  // single port, registered read; contents undefined until erased
  always_ff @(posedge aclk) begin
    if (bus.we) begin
      cells[bus.addr] <= bus.wdata;
    end
    bus.rdata <= cells[bus.addr];
  end
endmodule : epp_mem

//--- logic/epp_top.sv
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "epp_defs.svh"
// Function
// (R1) xa 10 with clock pulse loads command
// (R2) xa 00 loads address byte per bs
// (R3) xa 01 loads data byte
// (R4) ready flag low while operation runs
// (R5) eeprom read command drives eeprom byte
// (R6) fuse write command, zero programs
// (R7) bs lo high selects high fuse
// (R8) bs hi high selects extended fuse
// (R9) lock mode 3 blocks boot lock bits
// (R10) lock bits cleared only by erase
// (R11) fuse/lock read selected by bs pair
// (R12) signature read by low address 0..2
// (R13) bs lo high reads calibration byte
// (R14) serial needs reset low and enable
// (R15) sample rising, shift out falling
// (R16) programmer keeps sck phases long enough
// (R17) programmer powers up with sck low
// (R18) programmer waits before enable instruction
// (R19) echo second enable byte during third
// (R20) page filled low byte first
// (R21) page committed with high address bits
// (R22) only polling during write in progress
// (R23) serial eeprom write erases then writes
// (R24) chip erase sets arrays to 0xFF; the eeprom is left as is when ctrl_keep was set at erase start
// (R25) serial read returns addressed content
// (R26) reset high leaves programming mode
// (R27) four byte instructions, act after fourth
module epp_top #(
  parameter int FAW = 17, // flash byte address bits
  parameter int EAW = 12, // eeprom address bits
  parameter logic [7:0] SIG0 = 8'h5A, // arbitrary value
  parameter logic [7:0] SIG1 = 8'hA5, // arbitrary value
  parameter logic [7:0] SIG2 = 8'h3C, // arbitrary value
  parameter logic [7:0] CAL = 8'h80, // arbitrary value
  parameter int FUSE_WAIT = `EPP_FUSE_WAIT_US * `EPP_CLK_MHZ, // cycles
  parameter int FLASH_WAIT = `EPP_FLASH_WAIT_US * `EPP_CLK_MHZ, // cycles
  parameter int EE_WAIT = `EPP_EE_WAIT_US * `EPP_CLK_MHZ, // cycles
  parameter int ERASE_WAIT = `EPP_ERASE_WAIT_US * `EPP_CLK_MHZ // cycles
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [3:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [3:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic parallel_mode, // high voltage on reset pin
  input wire logic reset_pin_n, // device reset pin
  input wire logic clock_input_pin, // parallel load clock
  input wire logic write_strobe_n, // parallel write strobe
  input wire logic output_enable_n, // parallel read enable
  input wire logic transaction_select_hi, // load type high
  input wire logic transaction_select_lo, // load type low
  input wire logic low_byte_select, // byte select one
  input wire logic high_byte_select, // byte select two
  input wire logic [7:0] pp_data_in, // data bus in
  output logic [7:0] pp_data_out, // data bus out
  output logic pp_data_oe_n, // data bus drive, low drives
  output logic ready_busy_flag, // high when ready
  input wire logic serial_clock, // serial clock pin
  input wire logic serial_prog_in, // serial data in
  output logic serial_prog_out, // serial data out
  output logic cpu_run // normal operation
);
  // ********
  // pin synchronisers
  // ********
  logic [18:0] sy1, sy2;
  logic [2:0] prv;
  // two stages for every pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sy1 <= '0;
      sy2 <= '0;
      prv <= '0;
    end else begin
      sy1 <= {parallel_mode, reset_pin_n, clock_input_pin, write_strobe_n,
              output_enable_n, transaction_select_hi, transaction_select_lo,
              low_byte_select, high_byte_select, serial_clock,
              serial_prog_in, pp_data_in};
      sy2 <= sy1;
      prv <= {sy2[16], sy2[15], sy2[9]};
    end
  end
  wire par = sy2[18];
  wire rpin = sy2[17];
  wire oe_n = sy2[14];
  wire [1:0] xa = sy2[13:12];
  wire bs_lo = sy2[11];
  wire bs_hi = sy2[10];
  wire mosi = sy2[8];
  wire [7:0] din = sy2[7:0];
  wire ser = !rpin && !par; // [R14]
  wire xt_rise = sy2[16] && !prv[2];
  wire wr_fall = !sy2[15] && prv[1];
  wire sck_rise = sy2[9] && !prv[0];
  wire sck_fall = !sy2[9] && prv[0];
  // ********
  // state and shared signals
  // ********
  epp_pkg::epp_sweep_t sw;
  epp_pkg::epp_rsel_t rsel;
  logic [FAW:0] swp;
  logic [FAW-9:0] page;
  logic [19:0] wcnt;
  logic ee_keep, ctrl_keep, prog_en, pend1, pend2;
  logic [7:0] cmd, adr_lo, adr_hi, dat_lo;
  logic [7:0] fuse_lo, fuse_hi, fuse_ext, lock;
  logic [4:0] bitc;
  logic [31:0] sr;
  logic [7:0] out_sr, rd, pval;
  logic [1:0] sidx, fsel;
  logic [FAW-1:0] rf_addr;
  logic [EAW-1:0] ser_ea, ee_wa;
  logic [7:0] wdat, ldidx;
  logic do_erase, do_fuse, do_lock, do_ee, do_load, do_page, pdrive;
  wire busy = (sw != epp_pkg::SW_IDLE) || (wcnt != 20'h0);
  wire [31:0] w = {sr[30:0], mosi};
  wire exec = ser && sck_rise && (bitc == 5'h1F); // [R27]
  wire erase_end = (sw == epp_pkg::SW_ERASE) && (swp == {1'b0, {FAW{1'b1}}});
  wire lock_mode3 = (lock[1:0] == 2'b00);
  epp_mem_if #(.AW(FAW)) fl_if ();
  epp_mem_if #(.AW(EAW)) ee_if ();
  epp_mem_if #(.AW(8)) bf_if ();
  // ********
  // write request decode
  // ********
  // writes start only while idle, so arrays never see two writers
  always_comb begin
    do_erase = 1'b0;
    do_fuse = 1'b0;
    do_lock = 1'b0;
    do_ee = 1'b0;
    do_load = 1'b0;
    do_page = 1'b0;
    fsel = 2'b00;
    wdat = dat_lo;
    ee_wa = EAW'({w[19:16], w[15:8]});
    ldidx = {w[14:8], w[27]};
    if (par && wr_fall && !busy) begin
      if (cmd == `EPP_CMD_ERASE) do_erase = 1'b1;
      if (cmd == `EPP_CMD_FUSE) begin
        do_fuse = 1'b1; // [R6]
        fsel = {bs_hi, bs_lo}; // [R7] [R8]
      end
      if (cmd == `EPP_CMD_LOCK) do_lock = 1'b1; // [R9]
    end else if (exec && prog_en && !busy) begin
      wdat = w[7:0];
      if (w[31:24] == `EPP_SI_PEN) begin
        do_erase = (w[23:21] == `EPP_SI_ERASE);
        do_lock = (w[23:21] == `EPP_SI_WLOCK);
        do_fuse = (w[23:16] == `EPP_SI_WFUSE);
        if (w[23:21] == `EPP_SI_WLOCK) wdat = w[7:0] | `EPP_LOCK_TOP;
      end
      do_ee = (w[31:24] == `EPP_SI_WREE); // [R23]
      do_load = (w[31:24] == `EPP_SI_LDPL) || (w[31:24] == `EPP_SI_LDPH);
      do_page = (w[31:24] == `EPP_SI_WRPG); // [R21]
    end
  end
  // ********
  // fuse and lock storage
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fuse_lo <= `EPP_FUSE_LO_RST;
      fuse_hi <= `EPP_FUSE_HI_RST;
      fuse_ext <= `EPP_FUSE_EXT_RST;
    end else if (do_fuse) begin
      if (fsel == 2'b00) fuse_lo <= wdat; // [R6]
      if (fsel == 2'b01) fuse_hi <= wdat; // [R7]
      if (fsel == 2'b10) fuse_ext <= wdat; // [R8]
    end
  end
  // ones never clear a programmed bit; only erase or aresetn brings them back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock <= `EPP_LOCK_RST;
    end else if (erase_end) begin
      lock <= `EPP_LOCK_RST; // [R10]
    end else if (do_lock) begin
      lock <= lock & (lock_mode3 ? (wdat | `EPP_BOOT_LOCK_MASK) :
                      wdat); // [R9] [R10]
    end
  end
  // ********
  // erase, page copy and write timer
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw <= epp_pkg::SW_IDLE;
      swp <= '0;
      page <= '0;
      wcnt <= 20'h0;
      ee_keep <= 1'b0;
    end else if (do_erase) begin
      sw <= epp_pkg::SW_ERASE; // [R24]
      swp <= '0;
      wcnt <= 20'(ERASE_WAIT); // [R4]
      ee_keep <= ctrl_keep;
    end else if (do_page) begin
      sw <= epp_pkg::SW_COPY;
      swp <= '0;
      page <= (FAW-8)'({w[23:16], w[15]}); // [R21]
      wcnt <= 20'(FLASH_WAIT);
    end else if (do_fuse || do_lock) begin
      wcnt <= 20'(FUSE_WAIT); // [R4]
    end else if (do_ee) begin
      wcnt <= 20'(EE_WAIT);
    end else begin
      if (wcnt != 20'h0) wcnt <= wcnt - 20'h1;
      if (erase_end) sw <= epp_pkg::SW_IDLE;
      else if ((sw == epp_pkg::SW_COPY) && swp[8]) sw <= epp_pkg::SW_IDLE;
      else if (sw != epp_pkg::SW_IDLE) swp <= swp + 1'b1;
    end
  end
  // ********
  // array ports
  // ********
  // copy writes lag the buffer read by one cycle
  assign fl_if.we = (sw == epp_pkg::SW_ERASE) ||
                    ((sw == epp_pkg::SW_COPY) && (swp != '0));
  assign fl_if.addr = (sw == epp_pkg::SW_ERASE) ? swp[FAW-1:0] :
                      (sw == epp_pkg::SW_COPY) ?
                      {page, swp[7:0] - 8'h01} : rf_addr;
  assign fl_if.wdata = (sw == epp_pkg::SW_ERASE) ? `EPP_ERASED : bf_if.rdata;
  assign ee_if.we = ((sw == epp_pkg::SW_ERASE) && !ee_keep &&
                     ((swp >> EAW) == '0)) || do_ee; // [R24]
  assign ee_if.addr = (sw == epp_pkg::SW_ERASE) ? swp[EAW-1:0] :
                      do_ee ? ee_wa : ser ? ser_ea :
                      EAW'({adr_hi, adr_lo});
  assign ee_if.wdata = (sw == epp_pkg::SW_ERASE) ? `EPP_ERASED : wdat;
  assign bf_if.we = do_load; // [R20]
  assign bf_if.addr = (sw == epp_pkg::SW_COPY) ? swp[7:0] : ldidx;
  assign bf_if.wdata = wdat;
  epp_mem #(.AW(FAW)) u_flash (.aclk(aclk), .bus(fl_if.mem));
  epp_mem #(.AW(EAW)) u_eeprom (.aclk(aclk), .bus(ee_if.mem));
  epp_mem #(.AW(8)) u_pagebuf (.aclk(aclk), .bus(bf_if.mem));
  // ********
  // parallel port
  // ********
  always_ff @(posedge aclk) begin
    if (!aresetn || !par) begin
      cmd <= 8'h00;
      adr_lo <= 8'h00;
      adr_hi <= 8'h00;
      dat_lo <= 8'h00;
    end else if (xt_rise) begin
      if (xa == 2'b10) cmd <= din; // [R1]
      if (xa == 2'b00 && !bs_lo) adr_lo <= din; // [R2]
      if (xa == 2'b00 && bs_lo) adr_hi <= din; // [R2]
      if (xa == 2'b01 && !bs_lo) dat_lo <= din; // [R3]
    end
  end
  // read data picked by command and byte selects
  always_comb begin
    pval = `EPP_ERASED;
    pdrive = par && !oe_n;
    if (cmd == `EPP_CMD_RD_EE) begin
      pval = ee_if.rdata; // [R5]
    end else if (cmd == `EPP_CMD_RD_FL) begin
      if ({bs_hi, bs_lo} == 2'b00) pval = fuse_lo; // [R11]
      if ({bs_hi, bs_lo} == 2'b11) pval = fuse_hi;
      if ({bs_hi, bs_lo} == 2'b10) pval = fuse_ext;
      if ({bs_hi, bs_lo} == 2'b01) pval = lock;
    end else if (cmd == `EPP_CMD_RD_SIG) begin
      if (bs_lo) pval = CAL; // [R13]
      else if (adr_lo == 8'h00) pval = SIG0; // [R12]
      else if (adr_lo == 8'h01) pval = SIG1;
      else if (adr_lo == 8'h02) pval = SIG2;
    end else begin
      pdrive = 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pp_data_out <= 8'h00;
      pp_data_oe_n <= 1'b1;
      ready_busy_flag <= 1'b1;
      cpu_run <= 1'b0;
    end else begin
      pp_data_out <= pval;
      pp_data_oe_n <= !pdrive;
      ready_busy_flag <= !busy; // [R4]
      cpu_run <= rpin && !par; // [R26]
    end
  end
  // ********
  // serial port
  // ********
  // answer byte four comes from the array picked after byte three
  always_comb begin
    unique case (rsel)
      epp_pkg::RS_FLASH: rd = fl_if.rdata; // [R25]
      epp_pkg::RS_EE: rd = ee_if.rdata;
      epp_pkg::RS_LOCK: rd = lock;
      epp_pkg::RS_SIG: rd = (sidx == 2'h0) ? SIG0 : (sidx == 2'h1) ? SIG1 :
                            (sidx == 2'h2) ? SIG2 : `EPP_ERASED;
      default: rd = sr[7:0];
    endcase
  end
  // reset pin high drops the session and the enable with it
  always_ff @(posedge aclk) begin
    if (!aresetn || !ser) begin
      bitc <= 5'h00; // [R26]
      sr <= '0;
      prog_en <= 1'b0; // [R14]
      pend1 <= 1'b0;
      pend2 <= 1'b0;
      out_sr <= 8'h00;
      serial_prog_out <= 1'b0;
      rsel <= epp_pkg::RS_ECHO;
      sidx <= 2'h0;
      rf_addr <= '0;
      ser_ea <= '0;
    end else begin
      pend1 <= sck_rise && (bitc[2:0] == 3'h7);
      pend2 <= pend1;
      if (sck_rise) begin
        sr <= w; // [R15]
        bitc <= bitc + 5'h01;
        if (exec && (w[31:24] == `EPP_SI_PEN) &&
            (w[23:16] == `EPP_SI_SYNC)) prog_en <= 1'b1; // [R27]
        if (bitc == 5'h17) begin
          rf_addr <= FAW'({w[15:0], w[19]});
          ser_ea <= EAW'({w[11:8], w[7:0]});
          sidx <= w[1:0];
          rsel <= epp_pkg::RS_ECHO;
          if (prog_en) begin
            if (w[23:16] == `EPP_SI_RDPL || w[23:16] == `EPP_SI_RDPH)
              rsel <= epp_pkg::RS_FLASH; // [R25]
            if (w[23:16] == `EPP_SI_RDEE) rsel <= epp_pkg::RS_EE;
            if (w[23:16] == `EPP_SI_RDLK) rsel <= epp_pkg::RS_LOCK;
            if (w[23:16] == `EPP_SI_RDSIG) rsel <= epp_pkg::RS_SIG;
          end
        end
      end
      // the byte just received goes back out, except after byte three where rd goes out, so 0x53 echoes
      if (pend2) begin
        out_sr <= (bitc == 5'h18) ? rd : sr[7:0]; // [R19]
      end else if (sck_fall) begin
        serial_prog_out <= out_sr[7]; // [R15]
        out_sr <= {out_sr[6:0], 1'b0};
      end
    end
  end
  // ********
  // register bus
  // ********
  logic aw_full, w_full;
  logic [3:0] aw_a;
  logic [31:0] w_d;
  logic [3:0] w_s;
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  // address and data taken in either order, answered once both held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_a <= 4'h0;
      w_d <= 32'h0;
      w_s <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `EPP_RESP_OKAY;
      ctrl_keep <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_a <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_d <= s_axi_wdata;
        w_s <= s_axi_wstrb;
      end
      if (aw_full && w_full && !s_axi_bvalid) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_a == `EPP_REG_CTRL) ? `EPP_RESP_OKAY :
                       `EPP_RESP_SLVERR;
        if (aw_a == `EPP_REG_CTRL && w_s[0]) ctrl_keep <= w_d[0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `EPP_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `EPP_RESP_OKAY;
      unique case (s_axi_araddr)
        `EPP_REG_STATUS: s_axi_rdata <= {28'h0, par, ser, prog_en, busy};
        `EPP_REG_FUSE: s_axi_rdata <= {8'h00, fuse_ext, fuse_hi, fuse_lo};
        `EPP_REG_LOCK: s_axi_rdata <= {24'h0, lock};
        `EPP_REG_CTRL: s_axi_rdata <= {31'h0, ctrl_keep};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `EPP_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : epp_top

//--- logic/epp_top_fix.sv
`timescale 1ns/100ps

//--- verif/epp_checker.sv
`timescale 1ns/100ps
module epp_checker (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic parallel_mode, // parallel
  input wire logic reset_pin_n, // reset pin
  input wire logic write_strobe_n, // strobe
  input wire logic output_enable_n, // read enable
  input wire logic pp_data_oe_n, // bus drive
  input wire logic ready_busy_flag, // ready
  input wire logic serial_clock, // link clock
  input wire logic serial_prog_out, // link out
  input wire logic cpu_run // normal run
);
  // ********
  // properties
  // ********
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin filters are two flops deep, so allow for them
  sequence s_oe_off;
    output_enable_n [*6];
  endsequence
  sequence s_busy;
    !ready_busy_flag [*8];
  endsequence
  AST_BUSY_CAUSE: assert property (parallel_mode
    && $fell(ready_busy_flag) |-> $past(!write_strobe_n, 2))
    else $error("busy without strobe");
  AST_BUSY_ENDS: assert property ($fell(ready_busy_flag)
    |-> ##[1:1000] ready_busy_flag) else $error("busy never ends");
  AST_BUSY_HOLD: assert property ($fell(ready_busy_flag) |-> s_busy)
    else $error("busy too short");
  AST_BUS_FREE: assert property (s_oe_off |-> pp_data_oe_n)
    else $error("bus driven without read");
  AST_RUN: assert property (reset_pin_n && !parallel_mode [*6]
    |-> cpu_run) else $error("not running");
  AST_HALT: assert property (!reset_pin_n [*6] |-> !cpu_run)
    else $error("running in reset");
  AST_OUT_FALL: assert property ($changed(serial_prog_out)
    && !reset_pin_n && !parallel_mode |-> !serial_clock
    && ($past(serial_clock, 4) || $past(serial_clock, 5)))
    else $error("link out moved off falling edge");
  AST_RD_ANS: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("no read answer");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
endmodule : epp_checker
bind epp_top epp_checker u_chk (.*);

//--- verif/epp_prog_model.sv
`timescale 1ns/100ps
module epp_prog_model (
  output logic serial_clock, // link clock
  output logic serial_prog_in, // data to device
  input wire logic serial_prog_out // data from device
);
  // ********
  // serial programmer
  // ********
  // clock parked low from power-up, still between frames
  initial begin
    serial_clock = 1'h0;
    serial_prog_in = 1'h0;
  end
  // one whole four-byte frame, 200 ns clock, offset from aclk
  task frame(input logic [31:0] tx, output logic [31:0] rx);
    #7;
    for (int k = 31; k >= 0; k--) begin
      serial_prog_in = tx[k];
      #100;
      serial_clock = 1'h1;
      rx[k] = serial_prog_out;
      #100;
      serial_clock = 1'h0;
    end
    #100;
    serial_prog_in = ~serial_prog_in; // line no longer meaningful
  endtask : frame
endmodule : epp_prog_model

//--- verif/testbench.sv
`timescale 1ns/100ps
module testbench;
  // ********
  // signals
  // ********
  localparam logic [7:0] SG [3] = '{8'h5A, 8'hA5, 8'h3C}; // arbitrary value
  localparam logic [7:0] CL = 8'h80; // arbitrary value
  localparam int WT = 20;
  localparam logic [7:0] FV [3] = '{8'hE2, 8'h9D, 8'hF5};
  localparam logic [1:0] RS [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
  localparam logic [7:0] RV [4] = '{8'hE2, 8'h9D, 8'hF5, 8'hFF};
  localparam logic [7:0] LV [3] = '{8'hFC, 8'hFF, 8'h00};
  localparam logic [7:0] LE [3] = '{8'hFC, 8'hFC, 8'h3C};
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, parallel_mode = 1'h0;
  logic reset_pin_n = 1'h1, clock_input_pin = 1'h0, write_strobe_n = 1'h1;
  logic output_enable_n = 1'h1, transaction_select_hi = 1'h0;
  logic transaction_select_lo = 1'h0, low_byte_select = 1'h0;
  logic high_byte_select = 1'h0;
  logic [7:0] pp_data_in = 8'h00;
  logic [1:0] r;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0] pp_data_out;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic s_axi_rvalid, pp_data_oe_n, ready_busy_flag, serial_clock;
  wire logic serial_prog_in, serial_prog_out, cpu_run;
  int err_total = 0, n_tests = 0, cyc = 0, i;
  // small waits keep the run short
  epp_top #(.FAW(9), .EAW(6), .SIG0(SG[0]), .SIG1(SG[1]), .SIG2(SG[2]),
    .CAL(CL), .FUSE_WAIT(WT), .FLASH_WAIT(WT), .EE_WAIT(WT),
    .ERASE_WAIT(WT)) uut (.*);
  epp_prog_model u_prog (.serial_clock, .serial_prog_in, .serial_prog_out);
  // 40 MHz clock and hang guard
  initial forever #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  // ********
  // tasks
  // ********
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // ready is sampled at the falling edge, taken at the next rising one
  task axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic ha, hw, hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    hb = 1'h0;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask : axw
  task axr(input logic [3:0] a, output logic [31:0] d);
    logic ha, hr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    hr = 1'h0;
    while (!hr) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask : axr
  task pload(input logic [1:0] xa, input logic bs, input logic [7:0] d);
    @(posedge aclk);
    {transaction_select_hi, transaction_select_lo} <= xa;
    low_byte_select <= bs;
    pp_data_in <= d;
    repeat (6) @(posedge aclk);
    clock_input_pin <= 1'h1;
    repeat (6) @(posedge aclk);
    clock_input_pin <= 1'h0;
    repeat (6) @(posedge aclk);
  endtask : pload
  task wait_rdy();
    repeat (8) @(posedge aclk);
    do @(negedge aclk); while (ready_busy_flag !== 1'h1);
    @(posedge aclk);
  endtask : wait_rdy
  task pwrite(input logic [1:0] bs);
    {high_byte_select, low_byte_select} <= bs;
    repeat (6) @(posedge aclk);
    write_strobe_n <= 1'h0;
    repeat (6) @(posedge aclk);
    @(negedge aclk);
    chk(ready_busy_flag, 1'h0);
    @(posedge aclk);
    write_strobe_n <= 1'h1;
    wait_rdy();
    {high_byte_select, low_byte_select} <= 2'h0;
  endtask : pwrite
  // programmer lets go of the bus while the device answers
  task pread(input logic [1:0] bs, input logic [7:0] exp);
    @(posedge aclk);
    {high_byte_select, low_byte_select} <= bs;
    output_enable_n <= 1'h0;
    pp_data_in <= ~pp_data_in;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    chk({pp_data_oe_n, pp_data_out}, {1'h0, exp});
    @(posedge aclk);
    output_enable_n <= 1'h1;
    {high_byte_select, low_byte_select} <= 2'h0;
    repeat (8) @(posedge aclk);
  endtask : pread
  // ********
  // tests
  // ********
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    axr(4'h4, v);
    chk(v, 32'h00FFFFFF);
    axr(4'h8, v);
    chk(v, 32'hFF);
    axw(4'h4, 32'h0, r);
    chk(r, 2'h2);
    axw(4'hC, 32'h1, r);
    axr(4'hC, v);
    chk(v, 32'h1);
    s_axi_wstrb <= 4'h0;
    axw(4'hC, 32'h0, r);
    axr(4'hC, v);
    chk(v, 32'h1);
    s_axi_wstrb <= 4'hF;
    axw(4'hC, 32'h0, r);
    $display("test registers done");
    parallel_mode <= 1'h1;
    for (i = 0; i < 3; i++) begin
      pload(2'h2, 1'h0, 8'h40);
      pload(2'h1, 1'h0, FV[i]);
      pwrite(i[1:0]);
    end
    axr(4'h4, v);
    chk(v, 32'h00F59DE2);
    pload(2'h2, 1'h0, 8'h04);
    for (i = 0; i < 4; i++) pread(RS[i], RV[i]);
    for (i = 0; i < 3; i++) begin
      pload(2'h2, 1'h0, 8'h20);
      pload(2'h1, 1'h0, LV[i]);
      pwrite(2'h0);
      axr(4'h8, v);
      chk(v, {24'h0, LE[i]});
    end
    pload(2'h2, 1'h0, 8'h08);
    for (i = 0; i < 3; i++) begin
      pload(2'h0, 1'h0, i[7:0]);
      pread(2'h0, SG[i]);
    end
    pload(2'h0, 1'h0, 8'h00);
    pread(2'h1, CL);
    pload(2'h2, 1'h0, 8'h80);
    pwrite(2'h0);
    axr(4'h8, v);
    chk(v, 32'hFF);
    pload(2'h2, 1'h0, 8'h03);
    pload(2'h0, 1'h1, 8'h00);
    pload(2'h0, 1'h0, 8'h05);
    pread(2'h0, 8'hFF);
    $display("test parallel done");
    parallel_mode <= 1'h0;
    reset_pin_n <= 1'h0;
    repeat (20) @(posedge aclk);
    u_prog.frame(32'hC00005A7, v);
    wait_rdy();
    u_prog.frame(32'hAC530000, v);
    chk(v[15:8], 8'h53);
    axr(4'h0, v);
    chk(v, 32'h6);
    u_prog.frame(32'hA0000500, v);
    chk(v[7:0], 8'hFF);
    u_prog.frame(32'hC00005A7, v);
    wait_rdy();
    u_prog.frame(32'hA0000500, v);
    chk(v[7:0], 8'hA7);
    u_prog.frame(32'h4000035C, v);
    u_prog.frame(32'h480003C5, v);
    u_prog.frame(32'h4C000000, v);
    wait_rdy();
    u_prog.frame(32'h20000300, v);
    chk(v[7:0], 8'h5C);
    u_prog.frame(32'h28000300, v);
    chk(v[7:0], 8'hC5);
    u_prog.frame(32'h30000200, v);
    chk(v[7:0], SG[2]);
    reset_pin_n <= 1'h1;
    repeat (10) @(posedge aclk);
    @(negedge aclk);
    chk(cpu_run, 1'h1);
    axr(4'h0, v);
    chk(v, 32'h0);
    $display("test serial done");
    give_verdict();
  end
endmodule : testbench
